// *** logic/bwd_pkg.sv ***
package bwd_pkg;

   // ***************************************************************
   // clock and timing
   // ***************************************************************
   localparam int CLK_NS         = 8;
   localparam int FILT_MIN_NS    = 500;
   localparam int FILT_MAX_US    = 500;
   localparam int GAP_MAX_US     = 500;
   localparam int NR2N_MIN_US    = 15;
   localparam int CSWAKE_MIN_US  = 15;
   localparam int ATTN_PULSE_US  = 10;
   // strictly wider than the minimum: first whole cycle past it
   localparam int FILT_MIN_CYC   = FILT_MIN_NS / CLK_NS + 1;
   // strictly narrower than the maximum: last cycle before it
   localparam int FILT_MAX_CYC   = (FILT_MAX_US * 1000 + CLK_NS - 1) / CLK_NS - 1;
   localparam int GAP_MAX_CYC    = (GAP_MAX_US * 1000) / CLK_NS;
   localparam int NR2N_CYC       = (NR2N_MIN_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int CSWAKE_CYC     = (CSWAKE_MIN_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int ATTN_CYC       = (ATTN_PULSE_US * 1000) / CLK_NS;

   // ***************************************************************
   // serial commands
   // ***************************************************************
   localparam logic [7:0] CMD_KICK     = 8'h5a;
   localparam logic [7:0] CMD_XCVR_ON  = 8'h31;
   localparam logic [7:0] CMD_XCVR_OFF = 8'h30;
   localparam logic [7:0] CMD_WAKE_EN  = 8'h41;
   localparam logic [7:0] CMD_WAKE_DIS = 8'h40;
   localparam logic [7:0] CMD_HOLD     = 8'h66;
   localparam int         CMD_BITS     = 8;

   // ***************************************************************
   // reset values
   // ***************************************************************
   localparam logic RST_WAKE_EN = 1'b1;

   typedef enum logic [1:0] {
      MD_PROBATION,
      MD_NORMAL,
      MD_HOLD
   } bwd_mode_e;

   typedef struct packed {
      logic rx_n;
      logic sclk;
      logic cs_n;
      logic mosi;
   } bwd_pins_s;

endpackage : bwd_pkg

// *** logic/bwd_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module bwd_sync #(
   parameter int W = 4
) (
   input  wire logic         ref_clk,
   input  wire logic         sys_rst,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] s1_ff;
   logic [W-1:0] s2_ff;
   logic [W-1:0] s3_ff;

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         // idle-high defaults so rx_n and cs_n show no edge after reset; the low-idling serial clock shows one fall
         always_ff @(posedge ref_clk) begin
            if (sys_rst) begin
               s1_ff[i]    <= 1'b1;
               s2_ff[i]    <= 1'b1;
               s3_ff[i]    <= 1'b1;
               sync_out[i] <= 1'b1;
            end else begin
               s1_ff[i] <= async_in[i];
               s2_ff[i] <= s1_ff[i];
               s3_ff[i] <= s2_ff[i];
               if (s2_ff[i] == s3_ff[i]) begin
                  sync_out[i] <= s3_ff[i];
               end
            end
         end
      end
   endgenerate
endmodule : bwd_sync
`default_nettype wire

// *** logic/bwd_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module bwd_top
   import bwd_pkg::*;
#(
   parameter int FILT_MAX = bwd_pkg::FILT_MAX_CYC,
   parameter int GAP_MAX  = bwd_pkg::GAP_MAX_CYC
) (
   input  wire logic          ref_clk,
   input  wire logic          sys_rst,
   input  wire logic          bus_rx_n,
   input  wire logic          spi_sclk,
   input  wire logic          spi_cs_n,
   input  wire logic          spi_mosi,
   output logic               spi_miso,
   output logic               spi_miso_oe,
   output logic               attn_n,
   output logic               bus_wake,
   output logic               xcvr_active,
   output logic               wake_en,
   output bwd_pkg::bwd_mode_e mode
);
   import bwd_pkg::*;

   // ***************************************************************
   // input synchronisation
   // ***************************************************************
   bwd_pins_s pin_raw;
   bwd_pins_s pin;
   bwd_pins_s pin_d_ff;

   assign pin_raw = '{rx_n: bus_rx_n, sclk: spi_sclk, cs_n: spi_cs_n, mosi: spi_mosi};

   bwd_sync #(.W(4)) u_sync (
      .ref_clk  (ref_clk),
      .sys_rst  (sys_rst),
      .async_in (pin_raw),
      .sync_out (pin)
   );

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         pin_d_ff <= '{rx_n: 1'b1, sclk: 1'b1, cs_n: 1'b1, mosi: 1'b1};
      end else begin
         pin_d_ff <= pin;
      end
   end

   logic sclk_fall;
   logic sclk_rise;
   logic cs_rise;
   logic cs_fall;
   logic dom;
   logic dom_end;

   assign sclk_fall = pin_d_ff.sclk & ~pin.sclk;
   assign sclk_rise = ~pin_d_ff.sclk & pin.sclk;
   assign cs_rise   = pin_d_ff.cs_n == 1'b0 && pin.cs_n == 1'b1;
   assign cs_fall   = pin_d_ff.cs_n == 1'b1 && pin.cs_n == 1'b0;
   assign dom       = ~pin.rx_n;
   assign dom_end   = ~pin_d_ff.rx_n & pin.rx_n;

   // ***************************************************************
   // serial port
   // ***************************************************************
   logic [7:0] rx_sh_ff;
   logic [3:0] bit_cnt_ff;
   logic       cmd_stb_ff;
   logic [7:0] cmd_ff;
   logic [7:0] tx_sh_ff;
   logic [7:0] status;

   always_ff @(posedge ref_clk) begin
      if (sys_rst || pin.cs_n) begin
         rx_sh_ff   <= 8'h00;
         bit_cnt_ff <= 4'h0;
         cmd_stb_ff <= 1'b0;
         cmd_ff     <= 8'h00;
      end else begin
         cmd_stb_ff <= 1'b0;
         if (sclk_fall) begin
            rx_sh_ff <= {rx_sh_ff[6:0], pin.mosi};
            if (bit_cnt_ff == 4'(CMD_BITS - 1)) begin
               // command acts from the eighth falling edge
               cmd_stb_ff <= 1'b1;
               cmd_ff     <= {rx_sh_ff[6:0], pin.mosi};
               bit_cnt_ff <= 4'h0;
            end else begin
               bit_cnt_ff <= bit_cnt_ff + 4'h1;
            end
         end
      end
   end

   logic [1:0] pulse_cnt_ff;

   assign status = {mode, xcvr_active, bus_wake, wake_en, pulse_cnt_ff, 1'b0};

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         tx_sh_ff    <= 8'h00;
         spi_miso    <= 1'b0;
         spi_miso_oe <= 1'b0;
      end else begin
         spi_miso_oe <= ~pin.cs_n;
         if (cs_fall) begin
            tx_sh_ff <= status;
            spi_miso <= 1'b0;
         end else if (!pin.cs_n && sclk_rise) begin
            spi_miso <= tx_sh_ff[7];
            tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
         end
      end
   end

   // commands are taken only while awake; a hold-mode host waits out
   // the wake delays before talking
   logic cmd_ok;
   logic xcvr_on_evt;

   assign cmd_ok      = cmd_stb_ff && mode != MD_HOLD;
   assign xcvr_on_evt = cmd_ok && mode == MD_NORMAL && cmd_ff == CMD_XCVR_ON;

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         wake_en <= RST_WAKE_EN;
      end else if (cmd_ok && cmd_ff == CMD_WAKE_EN) begin
         wake_en <= 1'b1;
      end else if (cmd_ok && cmd_ff == CMD_WAKE_DIS) begin
         wake_en <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         xcvr_active <= 1'b0;
      end else if (xcvr_on_evt) begin
         xcvr_active <= 1'b1;
      end else if (cmd_ok && (cmd_ff == CMD_XCVR_OFF || cmd_ff == CMD_HOLD)) begin
         xcvr_active <= 1'b0;
      end
   end

   // ***************************************************************
   // bus wake filter
   // ***************************************************************
   logic [16:0] width_ff;
   logic [16:0] gap_ff;
   logic        gap_run_ff;
   logic        too_long;
   logic        width_ok;
   logic        accept;
   logic        discard;
   logic        gap_out;
   logic        wake_set;

   assign too_long = dom && width_ff == 17'(FILT_MAX);
   assign width_ok = width_ff >= 17'(FILT_MIN_CYC) && width_ff <= 17'(FILT_MAX);
   assign accept   = wake_en && dom_end && width_ok;
   assign discard  = wake_en && ((dom_end && !width_ok) || too_long);
   assign gap_out  = gap_run_ff && gap_ff > 17'(GAP_MAX);
   assign wake_set = accept && pulse_cnt_ff == 2'd2;

   always_ff @(posedge ref_clk) begin
      if (sys_rst || !dom) begin
         width_ff <= 17'h0;
      end else if (width_ff <= 17'(FILT_MAX)) begin
         width_ff <= width_ff + 17'h1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst || !wake_en || discard || xcvr_on_evt) begin
         gap_run_ff <= 1'b0;
         gap_ff     <= 17'h0;
      end else if (accept) begin
         gap_run_ff <= 1'b1;
         gap_ff     <= 17'h0;
      end else if (gap_out) begin
         gap_run_ff <= 1'b0;
         gap_ff     <= 17'h0;
      end else if (gap_run_ff && !dom) begin
         // spacing runs end to start: a pulse in progress freezes it
         gap_ff <= gap_ff + 17'h1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst || !wake_en) begin
         pulse_cnt_ff <= 2'd0;
      end else if (discard) begin
         pulse_cnt_ff <= 2'd0;
      end else if (accept && pulse_cnt_ff != 2'd3) begin
         pulse_cnt_ff <= pulse_cnt_ff + 2'd1;
      end else if (gap_out && !bus_wake) begin
         pulse_cnt_ff <= 2'd0;
      end else if (xcvr_on_evt) begin
         pulse_cnt_ff <= 2'd0;
      end
   end

   // set beats the completing command in the same cycle
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         bus_wake <= 1'b0;
      end else if (wake_set) begin
         bus_wake <= 1'b1;
      end else if (xcvr_on_evt) begin
         bus_wake <= 1'b0;
      end
   end

   // ***************************************************************
   // mode sequencing
   // ***************************************************************
   logic [15:0] dly_ff;
   logic        dly_run_ff;
   logic        hold_wake;

   assign hold_wake = mode == MD_HOLD && !dly_run_ff && (cs_rise || wake_set);

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         mode       <= MD_PROBATION;
         dly_ff     <= 16'h0;
         dly_run_ff <= 1'b0;
      end else begin
         unique case (mode)
            MD_PROBATION: begin
               if (dly_run_ff) begin
                  if (dly_ff == 16'(NR2N_CYC - 1)) begin
                     mode       <= MD_NORMAL;
                     dly_run_ff <= 1'b0;
                  end else begin
                     dly_ff <= dly_ff + 16'h1;
                  end
               end else if (cmd_ok && cmd_ff == CMD_KICK) begin
                  dly_run_ff <= 1'b1;
                  dly_ff     <= 16'h0;
               end
            end
            MD_NORMAL: begin
               // hold starts as the frame closes, so its own
               // chip-select release is not taken as a wake
               if (cmd_ok && cmd_ff == CMD_HOLD) begin
                  dly_run_ff <= 1'b1;
               end else if (dly_run_ff && cs_rise) begin
                  mode       <= MD_HOLD;
                  dly_run_ff <= 1'b0;
               end
            end
            MD_HOLD: begin
               if (hold_wake) begin
                  dly_run_ff <= 1'b1;
                  dly_ff     <= 16'h0;
               end else if (dly_run_ff) begin
                  if (dly_ff == 16'(CSWAKE_CYC - 1)) begin
                     mode       <= MD_PROBATION;
                     dly_run_ff <= 1'b0;
                  end else begin
                     dly_ff <= dly_ff + 16'h1;
                  end
               end
            end
         endcase
      end
   end

   // ***************************************************************
   // attention pulse
   // ***************************************************************
   logic [15:0] attn_cnt_ff;

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         attn_n      <= 1'b1;
         attn_cnt_ff <= 16'h0;
      end else if (hold_wake) begin
         attn_n      <= 1'b0;
         attn_cnt_ff <= 16'(ATTN_CYC - 1);
      end else if (attn_cnt_ff != 16'h0) begin
         attn_cnt_ff <= attn_cnt_ff - 16'h1;
      end else begin
         attn_n <= 1'b1;
      end
   end

endmodule : bwd_top
`default_nettype wire

// *** sim/bwd_chk_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module bwd_chk #(
   parameter int FILT_MAX = 200,
   parameter int GAP_MAX  = 300
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic bus_rx_n,
   input wire logic spi_sclk,
   input wire logic spi_cs_n,
   input wire logic spi_mosi,
   input wire logic spi_miso,
   input wire logic spi_miso_oe,
   input wire logic attn_n,
   input wire logic bus_wake,
   input wire logic xcvr_active,
   input wire logic wake_en,
   input var  bwd_pkg::bwd_mode_e mode
);
   import bwd_pkg::*;
   // ****************
   // helper counters
   // ****************
   logic [15:0] sf_ff, ar_ff, sw_ff, rr_ff;
   logic        sclk_q_ff, attn_q_ff, rx_q_ff;
   always_ff @(posedge ref_clk) begin
      sclk_q_ff <= spi_sclk;
      attn_q_ff <= attn_n;
      rx_q_ff <= bus_rx_n;
   end
   // cycles since the last pin-level serial clock fall; saturates
   always_ff @(posedge ref_clk) begin
      if (sys_rst) sf_ff <= 16'hffff;
      else if (sclk_q_ff && !spi_sclk) sf_ff <= 16'h0;
      else if (sf_ff != 16'hffff) sf_ff <= sf_ff + 16'h1;
   end
   always_ff @(posedge ref_clk) begin
      if (sys_rst || attn_n) ar_ff <= 16'h0;
      else ar_ff <= ar_ff + 16'h1;
   end
   always_ff @(posedge ref_clk) begin
      if (sys_rst) sw_ff <= 16'h0;
      else if (attn_q_ff && !attn_n) sw_ff <= 16'h1;
      else if (sw_ff != 16'h0 && sw_ff != 16'hffff) sw_ff <= sw_ff + 16'h1;
   end
   always_ff @(posedge ref_clk) begin
      if (sys_rst) rr_ff <= 16'hffff;
      else if (!rx_q_ff && bus_rx_n) rr_ff <= 16'h0;
      else if (rr_ff != 16'hffff) rr_ff <= rr_ff + 16'h1;
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   a_wake_cause: assert property ($rose(bus_wake) |-> wake_en && rr_ff <= 16'h000a)
      else $error("bus wake rose without a recent accepted pulse");
   a_flag_clear: assert property ($fell(bus_wake) |-> ##[0:2] (xcvr_active && mode == MD_NORMAL))
      else $error("bus wake dropped without transceiver activation");
   a_xcvr_timing: assert property ($rose(xcvr_active) |-> mode == MD_NORMAL && sf_ff <= 16'h04e2)
      else $error("transceiver activation late or outside normal mode");
   a_kick_delay: assert property (mode == MD_NORMAL && $past(mode) != MD_NORMAL
      |-> $past(mode) == MD_PROBATION && sf_ff >= 16'h0753 && sf_ff <= 16'h222e)
      else $error("normal mode entry outside its delay window");
   a_attn_len: assert property ($rose(attn_n) |-> ar_ff == 16'h04e2)
      else $error("attention pulse length wrong");
   a_attn_hold: assert property ($fell(attn_n) |-> $past(mode) == MD_HOLD)
      else $error("attention pulse outside hold mode");
   a_hold_exit: assert property (mode == MD_PROBATION && $past(mode) == MD_HOLD
      |-> sw_ff >= 16'h0744 && sw_ff <= 16'h2bf2)
      else $error("hold mode exit outside its delay window");
   a_miso_edge: assert property ($changed(spi_miso) && spi_miso_oe && $past(spi_miso_oe, 2)
      |-> spi_sclk)
      else $error("serial output changed while serial clock low");
endmodule : bwd_chk
bind bwd_top bwd_chk #(.FILT_MAX(FILT_MAX), .GAP_MAX(GAP_MAX)) u_chk (
   .ref_clk(ref_clk), .sys_rst(sys_rst), .bus_rx_n(bus_rx_n), .spi_sclk(spi_sclk),
   .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
   .spi_miso_oe(spi_miso_oe), .attn_n(attn_n), .bus_wake(bus_wake),
   .xcvr_active(xcvr_active), .wake_en(wake_en), .mode(mode)
);
`default_nettype wire

// *** sim/bwd_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module bwd_host_model (
   input  wire logic ref_clk,
   input  wire logic spi_miso,
   output var  bwd_pkg::bwd_pins_s pins
);
   import bwd_pkg::*;
   logic [7:0] rd;
   initial pins = '{rx_n: 1'b1, sclk: 1'b0, cs_n: 1'b1, mosi: 1'b0};
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : tick
   // slow half periods keep clear of the pin synchronisers
   task automatic xfer(input logic [7:0] cmd);
      @(posedge ref_clk);
      pins.cs_n <= 1'b0;
      tick(10);
      for (int i = 7; i >= 0; i--) begin
         pins.sclk <= 1'b1;
         pins.mosi <= cmd[i];
         tick(9);
         @(negedge ref_clk) rd[i] = spi_miso;
         tick(1);
         pins.sclk <= 1'b0;
         tick(10);
      end
      pins.cs_n <= 1'b1;
      pins.mosi <= ~pins.mosi;
      tick(10);
   endtask : xfer
   task automatic pulse(input int w, input int g);
      @(posedge ref_clk);
      pins.rx_n <= 1'b0;
      tick(w);
      pins.rx_n <= 1'b1;
      tick(g);
   endtask : pulse
   task automatic cs_wake();
      @(posedge ref_clk);
      pins.cs_n <= 1'b0;
      tick(20);
      pins.cs_n <= 1'b1;
      tick(20);
   endtask : cs_wake
endmodule : bwd_host_model
`default_nettype wire

// *** sim/test_bus_wake_detect_and_mode_timing.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_bus_wake_detect_and_mode_timing;
   import bwd_pkg::*;
   typedef struct {int w; int g; logic wk;} bwd_row_s;
   bwd_row_s rows [7] = '{'{100, 100, 1'b1}, '{63, 100, 1'b1}, '{62, 100, 1'b0},
      '{200, 100, 1'b1}, '{201, 100, 1'b0}, '{100, 290, 1'b1}, '{100, 320, 1'b0}};
   logic      ref_clk, sys_rst, spi_miso, spi_miso_oe, attn_n, bus_wake, xcvr_active, wake_en;
   bwd_pins_s pins;
   bwd_mode_e mode;
   int        n_mismatch = 0;
   int        compares = 0;
   int        cyc = 0;
   int        n;
   localparam logic [15:0] BIT_LO    = 16'h0000;
   localparam logic [15:0] BIT_HI    = 16'h0001;
   localparam logic [15:0] XC_ON     = 16'h0002;
   localparam logic [15:0] EXP_FLAGS = {12'h000, 1'b1, 2'b00, RST_WAKE_EN};
   localparam logic [15:0] EXP_STAT  = {8'h00, MD_PROBATION, 3'b000, RST_WAKE_EN, 3'b000};
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   bwd_top #(.FILT_MAX(200), .GAP_MAX(300)) DUT (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .bus_rx_n(pins.rx_n), .spi_sclk(pins.sclk),
      .spi_cs_n(pins.cs_n), .spi_mosi(pins.mosi), .spi_miso(spi_miso),
      .spi_miso_oe(spi_miso_oe), .attn_n(attn_n), .bus_wake(bus_wake),
      .xcvr_active(xcvr_active), .wake_en(wake_en), .mode(mode)
   );
   bwd_host_model host (.ref_clk(ref_clk), .spi_miso(spi_miso), .pins(pins));
   task automatic stop_test();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : stop_test
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic do_reset();
      @(posedge ref_clk);
      sys_rst <= 1'b1;
      host.tick(12);
      sys_rst <= 1'b0;
      host.tick(5);
   endtask : do_reset
   task automatic wait_mode(input bwd_mode_e m, output int c);
      c = 0;
      @(negedge ref_clk);
      while (mode !== m && c < 20000) begin
         @(negedge ref_clk);
         c++;
      end
      @(posedge ref_clk);
   endtask : wait_mode
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 40000) begin
         n_mismatch++;
         stop_test();
      end
   end
   initial begin
      sys_rst = 1'b1;
      foreach (rows[i]) begin
         do_reset();
         repeat (3) host.pulse(rows[i].w, rows[i].g);
         @(negedge ref_clk);
         chk("row_wake", 16'(rows[i].wk), 16'(bus_wake));
      end
      do_reset();
      @(negedge ref_clk);
      chk("rst_mode", 16'(MD_PROBATION), 16'(mode));
      chk("rst_flags", EXP_FLAGS, {12'h0, attn_n, bus_wake, xcvr_active, wake_en});
      host.xfer(8'h00);
      chk("status", EXP_STAT, 16'(host.rd));
      chk("oe_idle", BIT_LO, 16'(spi_miso_oe));
      host.pulse(100, 100);
      host.pulse(40, 100);
      repeat (2) host.pulse(100, 100);
      @(negedge ref_clk);
      chk("discard_clears", BIT_LO, 16'(bus_wake));
      host.pulse(100, 100);
      host.xfer(CMD_XCVR_ON);
      @(negedge ref_clk);
      chk("flag_held", BIT_HI, {14'h0, xcvr_active, bus_wake});
      host.xfer(CMD_KICK);
      host.tick(1830);
      @(negedge ref_clk);
      chk("kick_early", 16'(MD_PROBATION), 16'(mode));
      host.tick(300);
      @(negedge ref_clk);
      chk("kick_done", 16'(MD_NORMAL), 16'(mode));
      host.xfer(CMD_XCVR_ON);
      @(negedge ref_clk);
      chk("xcvr_on", XC_ON, {14'h0, xcvr_active, bus_wake});
      repeat (2) host.pulse(100, 100);
      @(negedge ref_clk);
      chk("count_cleared", BIT_LO, 16'(bus_wake));
      host.pulse(100, 100);
      @(negedge ref_clk);
      chk("count_rewake", BIT_HI, 16'(bus_wake));
      host.xfer(CMD_XCVR_ON);
      host.xfer(CMD_WAKE_DIS);
      repeat (3) host.pulse(100, 100);
      @(negedge ref_clk);
      chk("wake_disabled", BIT_LO, {14'h0, wake_en, bus_wake});
      host.xfer(CMD_WAKE_EN);
      host.xfer(CMD_HOLD);
      @(negedge ref_clk);
      chk("hold", 16'(MD_HOLD), 16'(mode));
      host.cs_wake();
      @(negedge ref_clk);
      chk("attn_low", BIT_LO, 16'(attn_n));
      wait_mode(MD_PROBATION, n);
      chk("cs_wake_delay", BIT_HI, 16'(n + 20 >= 1875 && n + 20 <= 11250));
      host.tick(11300);
      host.xfer(CMD_KICK);
      host.tick(2200);
      @(negedge ref_clk);
      chk("kick_after_wake", 16'(MD_NORMAL), 16'(mode));
      stop_test();
   end
endmodule : test_bus_wake_detect_and_mode_timing
`default_nettype wire
